/* File: design/sfpc_host.sv */
// Host-side sequencer driving a sector-programmed parallel flash over its pins
// Function
// - Host loads a byte by pulsing write strobe low, select low, drive high.
// - Programming covers whole sectors; unloaded bytes become indeterminate.
// - Host starts each next load within 150 us of the previous rise.
// - Upper ten address lines hold the sector, lower eight the byte.
// - A fixed three-command sequence turns the write guard on.
// - With the guard on, every program cycle starts with those three commands.
// - After the cycle, reads return true data and a new cycle may begin.
`include "sfpc_defines.svh"
module sfpc_host #(
	parameter sfpc_pkg::sfpc_cnt_t WC_CYC  = sfpc_pkg::sfpc_cnt_t'(`SFPC_WC_CYC),
	parameter sfpc_pkg::sfpc_cnt_t PWR_CYC = sfpc_pkg::sfpc_cnt_t'(`SFPC_PWR_CYC)
) (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic                    clk_en,
	input  wire logic                    cmd_valid,
	output logic                         cmd_ready,
	input  wire sfpc_pkg::sfpc_op_t      cmd_op,
	input  wire logic [17:0]             cmd_addr,
	input  wire logic [7:0]              cmd_data,
	output logic                         rsp_valid,
	output logic [7:0]                   rsp_data,
	input  wire logic                    guard_assume,
	input  wire logic                    supply_ok,
	output logic                         flash_ce_b,
	output logic                         flash_oe_b,
	output logic                         flash_we_b,
	output logic [17:0]                  flash_addr,
	input  wire logic [7:0]              flash_data_in,
	output logic [7:0]                   flash_data_out,
	output logic                         flash_data_oe,
	output logic                         busy,
	output logic                         loading,
	output logic                         power_ready,
	output logic                         software_write_guard,
	output logic                         cycle_error,
	output logic                         sector_incomplete
);

	sfpc_pkg::sfpc_state_t state, next_state;
	sfpc_pkg::sfpc_cnt_t   step_count, win_count, win_remain;
	logic [1:0]            step;
	logic [17:0]           usr_addr, last_addr;
	logic [7:0]            usr_data, last_data;
	logic [9:0]            sector;
	logic [255:0]          loaded;
	logic [8:0]            pin_raw;
	wire logic [8:0]       pin_sync;
	logic                  unlocking, guard_op, guard_cycle, closing, poll_first, prev6;
	logic                  pwr_started, step_start, step_done, win_start, win_done, pwr_done;
	logic                  accept, rd_done, seq_more, wr_end, prog_start, timeout, unlock_first;
	logic [15:0]           gap_cnt;

	// Guard sequence address and data by step
	function automatic logic [17:0] unlk_addr(input logic [1:0] idx);
		case (idx)
			2'h0: unlk_addr = `SFPC_UNLK_ADDR0;
			2'h1: unlk_addr = `SFPC_UNLK_ADDR1;
			default: unlk_addr = `SFPC_UNLK_ADDR2;
		endcase
	endfunction : unlk_addr

	function automatic logic [7:0] unlk_data(input logic [1:0] idx);
		case (idx)
			2'h0: unlk_data = `SFPC_UNLK_DATA0;
			2'h1: unlk_data = `SFPC_UNLK_DATA1;
			default: unlk_data = `SFPC_UNLK_DATA2;
		endcase
	endfunction : unlk_data

	////////////////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for data lines and supply sense
	assign pin_raw = {supply_ok, flash_data_in};
	for (genvar i = 0; i < 9; i++) begin : g_sync
		logic meta, held;
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				meta <= 1'b0;
				held <= 1'b0;
			end else if (clk_en) begin
				meta <= pin_raw[i];
				held <= meta;
			end
		end
		assign pin_sync[i] = held;
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Timers: phase widths, load window / cycle limit, power-on wait
	sfpc_timer u_step (
		.clk    (clk),
		.rst_b  (rst_b),
		.en     (clk_en),
		.start  (step_start),
		.count  (step_count),
		.done   (step_done),
		.remain ()
	);

	sfpc_timer u_win (
		.clk    (clk),
		.rst_b  (rst_b),
		.en     (clk_en),
		.start  (win_start),
		.count  (win_count),
		.done   (win_done),
		.remain (win_remain)
	);

	sfpc_timer u_pwr (
		.clk    (clk),
		.rst_b  (rst_b),
		.en     (clk_en),
		.start  (!pin_sync[8] || !pwr_started),
		.count  (PWR_CYC),
		.done   (pwr_done),
		.remain ()
	);

	// Power wait restarts whenever supply sense drops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwr_started <= 1'b0;
		end else if (clk_en) begin
			pwr_started <= 1'b1;
		end
	end

	assign power_ready = pwr_started && pin_sync[8] && pwr_done;

	////////////////////////////////////////////////////////////////////////////////////////
	// Events
	assign accept       = cmd_valid && cmd_ready;
	assign rd_done      = (state == sfpc_pkg::ST_RD_WAIT) && step_done;
	assign seq_more     = (state == sfpc_pkg::ST_WR_HIGH) && unlocking && !(step == 2'h2 && guard_op);
	assign wr_end       = (state == sfpc_pkg::ST_WR_HIGH) && !seq_more;
	assign prog_start   = (state == sfpc_pkg::ST_IDLE) && loading && !busy && win_done;
	assign timeout      = busy && win_done;
	assign unlock_first = (cmd_op == sfpc_pkg::OP_GUARD) ||
	                      ((software_write_guard || guard_assume) && !loading);
	assign step_start   = (next_state != state);
	assign win_start    = wr_end || prog_start;
	assign win_count    = prog_start ? WC_CYC
	                      : sfpc_pkg::sfpc_cnt_t'(`SFPC_LOAD_CYC + `SFPC_LOAD_SLACK);

	// Request acceptance per operation
	always_comb begin
		cmd_ready = 1'b0;
		if (state == sfpc_pkg::ST_IDLE && !busy && !prog_start) begin
			case (cmd_op)
				sfpc_pkg::OP_READ: cmd_ready = !loading;
				sfpc_pkg::OP_LOAD: cmd_ready = power_ready && (!loading || (!closing
				                   && cmd_addr[17:8] == sector
				                   && win_remain > sfpc_pkg::sfpc_cnt_t'(`SFPC_LOAD_LATE)));
				sfpc_pkg::OP_FINISH: cmd_ready = loading && !closing;
				sfpc_pkg::OP_GUARD: cmd_ready = power_ready && !loading;
				default: cmd_ready = 1'b0;
			endcase
		end
	end

	// Phase widths
	always_comb begin
		case (next_state)
			sfpc_pkg::ST_WR_LOW: step_count = sfpc_pkg::sfpc_cnt_t'(`SFPC_WE_LOW_CYC);
			sfpc_pkg::ST_RD_WAIT: step_count = sfpc_pkg::sfpc_cnt_t'(`SFPC_RD_CYC);
			default: step_count = sfpc_pkg::sfpc_cnt_t'(1);
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			sfpc_pkg::ST_IDLE: begin
				if (busy) begin
					next_state = sfpc_pkg::ST_RD_WAIT;
				end else if (accept && (cmd_op == sfpc_pkg::OP_READ)) begin
					next_state = sfpc_pkg::ST_RD_WAIT;
				end else if (accept && (cmd_op != sfpc_pkg::OP_FINISH)) begin
					next_state = sfpc_pkg::ST_WR_SETUP;
				end
			end
			sfpc_pkg::ST_WR_SETUP: next_state = sfpc_pkg::ST_WR_LOW;
			sfpc_pkg::ST_WR_LOW: begin
				if (step_done) begin
					next_state = sfpc_pkg::ST_WR_HIGH;
				end
			end
			sfpc_pkg::ST_WR_HIGH: next_state = seq_more ? sfpc_pkg::ST_WR_SETUP : sfpc_pkg::ST_IDLE;
			sfpc_pkg::ST_RD_WAIT: begin
				if (step_done) begin
					next_state = sfpc_pkg::ST_RD_END;
				end
			end
			sfpc_pkg::ST_RD_END: next_state = sfpc_pkg::ST_IDLE;
			default: next_state = sfpc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= sfpc_pkg::ST_IDLE;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// Pin drive, registered from the next state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flash_ce_b     <= 1'b1;
			flash_oe_b     <= 1'b1;
			flash_we_b     <= 1'b1;
			flash_data_oe  <= 1'b0;
			flash_addr     <= 18'h00000;
			flash_data_out <= 8'h00;
		end else if (clk_en) begin
			flash_ce_b    <= (next_state == sfpc_pkg::ST_IDLE) || (next_state == sfpc_pkg::ST_RD_END);
			flash_oe_b    <= (next_state != sfpc_pkg::ST_RD_WAIT);
			flash_we_b    <= (next_state != sfpc_pkg::ST_WR_LOW);
			flash_data_oe <= (next_state == sfpc_pkg::ST_WR_SETUP) ||
			                 (next_state == sfpc_pkg::ST_WR_LOW) || (next_state == sfpc_pkg::ST_WR_HIGH);
			if (state == sfpc_pkg::ST_IDLE && next_state == sfpc_pkg::ST_WR_SETUP) begin
				flash_addr     <= unlock_first ? unlk_addr(2'h0) : cmd_addr;
				flash_data_out <= unlock_first ? unlk_data(2'h0) : cmd_data;
			end else if (seq_more) begin
				flash_addr     <= (step == 2'h2) ? usr_addr : unlk_addr(step + 2'h1);
				flash_data_out <= (step == 2'h2) ? usr_data : unlk_data(step + 2'h1);
			end else if (state == sfpc_pkg::ST_IDLE && next_state == sfpc_pkg::ST_RD_WAIT) begin
				flash_addr     <= busy ? last_addr : cmd_addr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Command sequence: guard prefix then user byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			unlocking <= 1'b0;
			step      <= 2'h0;
			guard_op  <= 1'b0;
			usr_addr  <= 18'h00000;
			usr_data  <= 8'h00;
		end else if (clk_en) begin
			if (accept && (cmd_op == sfpc_pkg::OP_LOAD || cmd_op == sfpc_pkg::OP_GUARD)) begin
				unlocking <= unlock_first;
				step      <= 2'h0;
				guard_op  <= (cmd_op == sfpc_pkg::OP_GUARD);
				usr_addr  <= cmd_addr;
				usr_data  <= cmd_data;
			end else if (seq_more) begin
				if (step == 2'h2) begin
					unlocking <= 1'b0;
				end else begin
					step <= step + 2'h1;
				end
			end
		end
	end

	// Load period bookkeeping
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loading              <= 1'b0;
			closing              <= 1'b0;
			sector               <= 10'h000;
			last_addr            <= 18'h00000;
			last_data            <= 8'h00;
			guard_cycle          <= 1'b0;
			software_write_guard <= 1'b0;
		end else if (clk_en) begin
			if (prog_start) begin
				loading <= 1'b0;
				closing <= 1'b0;
			end else begin
				if (wr_end) begin
					loading <= 1'b1;
				end
				if (accept && (cmd_op == sfpc_pkg::OP_FINISH || cmd_op == sfpc_pkg::OP_GUARD)) begin
					closing <= 1'b1;
				end
			end
			if (wr_end) begin
				sector      <= usr_addr[17:8];
				last_addr   <= guard_op ? unlk_addr(2'h2) : usr_addr;
				last_data   <= guard_op ? unlk_data(2'h2) : usr_data;
				guard_cycle <= guard_op;
			end
			if (wr_end && guard_op) begin
				software_write_guard <= 1'b1;
			end
		end
	end

	// Bytes loaded in the current sector
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loaded <= '0;
		end else if (clk_en) begin
			if (accept && !loading && cmd_op != sfpc_pkg::OP_READ) begin
				loaded <= '0;
			end else if (wr_end && !guard_op) begin
				loaded[usr_addr[7:0]] <= 1'b1;
			end
		end
	end

	// Program cycle wait by data and alternating-line polling
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy              <= 1'b0;
			poll_first        <= 1'b0;
			prev6             <= 1'b0;
			cycle_error       <= 1'b0;
			sector_incomplete <= 1'b0;
		end else if (clk_en) begin
			if (prog_start) begin
				busy              <= 1'b1;
				poll_first        <= 1'b1;
				cycle_error       <= 1'b0;
				sector_incomplete <= !guard_cycle && !(&loaded);
			end else if (timeout && state == sfpc_pkg::ST_RD_END) begin // Between polls only
				busy        <= 1'b0;
				cycle_error <= 1'b1;
			end else if (rd_done && busy) begin
				poll_first <= 1'b0;
				prev6      <= pin_sync[6];
				if (!poll_first && (guard_cycle || pin_sync[7] == last_data[7])
				    && pin_sync[6] == prev6) begin
					busy <= 1'b0;
				end
			end
		end
	end

	// Read answers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rsp_valid <= 1'b0;
			rsp_data  <= 8'h00;
		end else if (clk_en) begin
			rsp_valid <= rd_done && !busy;
			if (rd_done && !busy) begin
				rsp_data <= pin_sync[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Checks
	localparam int LOAD_LIM = `SFPC_LOAD_CYC;

	// Cycles since the last rising write strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_cnt <= 16'h0000;
		end else if (clk_en) begin
			if (!flash_we_b) begin
				gap_cnt <= 16'h0000;
			end else if (gap_cnt != 16'hffff) begin
				gap_cnt <= gap_cnt + 16'h0001;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence guard_go;
		state == sfpc_pkg::ST_WR_SETUP && unlocking && step == 2'h0;
	endsequence

	sequence first_fall;
		##[1:8] $fell(flash_we_b);
	endsequence

	strobe_gating_a: assert property (!flash_we_b |-> !flash_ce_b && flash_oe_b && flash_data_oe)
		else $error("write strobe low without select low and drive high");
	addr_held_a: assert property (!flash_we_b && $past(flash_we_b) == 1'b0 |->
		$stable(flash_addr) && $stable(flash_data_out))
		else $error("address or data moved during write strobe");
	data_hold_a: assert property ($rose(flash_we_b) |-> flash_data_oe && !flash_ce_b)
		else $error("data released at strobe rise");
	load_gap_a: assert property ($fell(flash_we_b) && loading |-> gap_cnt <= LOAD_LIM)
		else $error("next byte load too late");
	sector_same_a: assert property (!flash_we_b && loading && !unlocking |->
		flash_addr[17:8] == sector)
		else $error("load outside the open sector");
	guard_order_a: assert property (guard_go |-> flash_addr == unlk_addr(2'h0)
		&& flash_data_out == unlk_data(2'h0) ##0 first_fall)
		else $error("guard sequence did not open with its first command");
	busy_quiet_a: assert property (busy |-> flash_we_b && !cmd_ready)
		else $error("write or request during program cycle");
	poll_addr_a: assert property (busy && state == sfpc_pkg::ST_RD_WAIT |->
		flash_addr == last_addr && !flash_oe_b)
		else $error("poll read not at last loaded address");
	power_block_a: assert property (accept && cmd_op == sfpc_pkg::OP_LOAD |-> power_ready)
		else $error("load accepted before power wait ended");

endmodule : sfpc_host

/* File: design/sfpc_defines.svh */
// Widths, timing figures and command codes for the flash program controller
`ifndef SFPC_DEFINES_SVH
`define SFPC_DEFINES_SVH

// Pin widths, sector split and timer width
`define SFPC_ADDR_W      18
`define SFPC_SECT_LSB    8
`define SFPC_TMR_W       20

// Clock and times in nanoseconds
`define SFPC_CLK_NS      40
`define SFPC_T_ACC_NS    90
`define SFPC_T_GLITCH_NS 15
`define SFPC_T_LOAD_NS   150000
`define SFPC_T_WC_NS     10000000
`define SFPC_T_PWR_NS    5000000

// Cycle counts derived from the times, plus the fixed synchroniser depth
`define SFPC_ACC_CYC     ((`SFPC_T_ACC_NS + `SFPC_CLK_NS - 1) / `SFPC_CLK_NS)
`define SFPC_SYNC_CYC    2
`define SFPC_RD_CYC      (`SFPC_ACC_CYC + `SFPC_SYNC_CYC + 1)
`define SFPC_WE_LOW_CYC  ((`SFPC_T_GLITCH_NS + `SFPC_CLK_NS - 1) / `SFPC_CLK_NS)
`define SFPC_LOAD_CYC    (`SFPC_T_LOAD_NS / `SFPC_CLK_NS)
`define SFPC_WC_CYC      (`SFPC_T_WC_NS / `SFPC_CLK_NS)
`define SFPC_PWR_CYC     ((`SFPC_T_PWR_NS + `SFPC_CLK_NS - 1) / `SFPC_CLK_NS)

// Window slack past the device timeout, and last safe moment for a new load
`define SFPC_LOAD_SLACK  8
`define SFPC_LOAD_LATE   12

// Three-command guard sequence
`define SFPC_UNLK_ADDR0  18'h00aa1
`define SFPC_UNLK_ADDR1  18'h00554
`define SFPC_UNLK_ADDR2  18'h00aa1
`define SFPC_UNLK_DATA0  8'h3c
`define SFPC_UNLK_DATA1  8'hc3
`define SFPC_UNLK_DATA2  8'h5a

`endif

/* File: design/sfpc_pkg.sv */
// Types shared by the flash program controller
`include "sfpc_defines.svh"
package sfpc_pkg;

	// Requests taken on the user port
	typedef enum logic [1:0] {
		OP_READ   = 2'h0,
		OP_LOAD   = 2'h1,
		OP_FINISH = 2'h2,
		OP_GUARD  = 2'h3
	} sfpc_op_t;

	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE     = 6'h01,
		ST_WR_SETUP = 6'h02,
		ST_WR_LOW   = 6'h04,
		ST_WR_HIGH  = 6'h08,
		ST_RD_WAIT  = 6'h10,
		ST_RD_END   = 6'h20
	} sfpc_state_t;

	typedef logic [`SFPC_TMR_W-1:0] sfpc_cnt_t;

endpackage : sfpc_pkg

/* File: design/sfpc_timer.sv */
// Loadable down counter for strobe widths, load windows and waits
module sfpc_timer (
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic                en,
	input  wire logic                start,
	input  wire sfpc_pkg::sfpc_cnt_t count,
	output logic                     done,
	output sfpc_pkg::sfpc_cnt_t      remain
);

	// Load on start, count down to zero and hold
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			remain <= '0;
		end else if (en) begin
			if (start) begin
				remain <= count;
			end else if (remain != '0) begin
				remain <= remain - sfpc_pkg::sfpc_cnt_t'(1);
			end
		end
	end

	assign done = (remain == '0);

endmodule : sfpc_timer

/* File: sim/sfpc_flash_model.sv */
// Behavioural sector flash seen from its pins, standing in for the device
`include "sfpc_defines.svh"
module sfpc_flash_model #(
	parameter real T_LOAD_NS   = 150000.0,
	parameter real T_GLITCH_NS = 15.0,
	parameter real T_PWR_NS    = 1000.0
) (
	input  wire logic        ce_b,
	input  wire logic        oe_b,
	input  wire logic        we_b,
	input  wire logic [17:0] addr,
	input  wire logic [7:0]  dq_in,
	input  wire logic        supply_ok,
	input  wire logic [31:0] wc_ns,
	output logic [7:0]       dq_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]  mem [int];
	logic [25:0] queue_q [$];
	logic [17:0] a_lat;
	logic [7:0]  last_d;
	logic [7:0]  last_rd;
	logic        loading = 1'h0;
	logic        prog    = 1'h0;
	logic        tog     = 1'h0;
	logic        guarded = 1'h0; // Guard off as delivered, never cleared by power
	realtime     t_fall  = 0.0;
	realtime     t_rise  = 0.0;
	realtime     t_sup   = 0.0;
	wire         stb_low = !ce_b && !we_b && oe_b;
	wire         read_on = !ce_b && !oe_b && we_b;

	////////////////////////////////////////////////////////////////////////////////
	// Supply rise time for the power-on hold-off
	always @(posedge supply_ok) t_sup = $realtime;

	// Address on the later falling strobe edge
	always @(posedge stb_low) begin
		t_fall = $realtime;
		a_lat = addr;
	end

	// Data on the first rising edge; short pulses and busy-time strobes ignored
	always @(negedge stb_low) begin
		if (!prog && $realtime - t_fall >= T_GLITCH_NS) begin
			queue_q.push_back({a_lat, dq_in});
			last_d = dq_in;
			t_rise = $realtime;
			loading = 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Poll answers while programming, array data otherwise, drift when released
	always @(posedge read_on) if (prog) tog = ~tog;
	always @(read_on or prog or tog or addr) begin
		if (read_on && prog) begin
			dq_out = {~last_d[7], tog, last_d[5:0]};
			last_rd = dq_out;
		end else if (read_on) begin
			dq_out = mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hff;
			last_rd = dq_out;
		end else begin
			dq_out = ~last_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Quiet window closes the load period and starts the internal cycle
	always begin
		#10;
		if (loading && !stb_low && $realtime - t_rise >= T_LOAD_NS) begin
			loading = 1'h0;
			if (supply_ok && $realtime - t_sup >= T_PWR_NS)
				run_cycle();
			queue_q.delete();
		end
	end

	// Erase the sector, then write the latched bytes after the cycle time
	task automatic run_cycle();
		logic unlock;
		int   first;
		unlock = queue_q.size() >= 3 && queue_q[0] == {`SFPC_UNLK_ADDR0, `SFPC_UNLK_DATA0}
			&& queue_q[1] == {`SFPC_UNLK_ADDR1, `SFPC_UNLK_DATA1}
			&& queue_q[2] == {`SFPC_UNLK_ADDR2, `SFPC_UNLK_DATA2};
		first = unlock ? 3 : 0;
		prog = 1'h1;
		#(wc_ns);
		if (unlock)
			guarded = 1'h1;
		if ((unlock || !guarded) && queue_q.size() > first) begin
			for (int j = 0; j < 256; j++)
				mem[int'({queue_q[first][25:16], 8'(j)})] = 8'hff;
			for (int i = first; i < queue_q.size(); i++)
				mem[int'(queue_q[i][25:8])] = queue_q[i][7:0];
		end
		prog = 1'h0;
	endtask : run_cycle
endmodule : sfpc_flash_model

/* File: sim/tb_sfpc_host.sv */
// Self-checking bench for the host-side flash program sequencer
module tb_sfpc_host;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int WC_CYC  = 200;
	localparam int PWR_CYC = 50;

	logic               clk;
	logic               rst_b;
	logic               clk_en;
	logic               cmd_valid;
	logic               cmd_ready;
	sfpc_pkg::sfpc_op_t cmd_op;
	logic [17:0]        cmd_addr;
	logic [7:0]         cmd_data;
	logic               rsp_valid;
	logic [7:0]         rsp_data;
	logic               guard_assume;
	logic               supply_ok;
	logic               flash_ce_b;
	logic               flash_oe_b;
	logic               flash_we_b;
	logic [17:0]        flash_addr;
	logic [7:0]         flash_data_in;
	logic [7:0]         flash_data_out;
	logic               flash_data_oe;
	logic [7:0]         dev_dq;
	logic               busy;
	logic               loading;
	logic               power_ready;
	logic               software_write_guard;
	logic               cycle_error;
	logic               sector_incomplete;
	logic [31:0]        wc_ns;
	int                 errors = 0;
	int                 total_checks = 0;

	// Shared data lines: host drive wins, else whatever the device shows
	assign flash_data_in = flash_data_oe ? flash_data_out : dev_dq;

	sfpc_host #(
		.WC_CYC (sfpc_pkg::sfpc_cnt_t'(WC_CYC)),
		.PWR_CYC(sfpc_pkg::sfpc_cnt_t'(PWR_CYC))
	) sfpc_host_inst (
		.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .guard_assume(guard_assume),
		.supply_ok(supply_ok), .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b),
		.flash_we_b(flash_we_b), .flash_addr(flash_addr), .flash_data_in(flash_data_in),
		.flash_data_out(flash_data_out), .flash_data_oe(flash_data_oe), .busy(busy),
		.loading(loading), .power_ready(power_ready),
		.software_write_guard(software_write_guard), .cycle_error(cycle_error),
		.sector_incomplete(sector_incomplete)
	);

	sfpc_flash_model sfpc_flash_model_inst (
		.ce_b(flash_ce_b), .oe_b(flash_oe_b), .we_b(flash_we_b), .addr(flash_addr),
		.dq_in(flash_data_in), .supply_ok(supply_ok), .wc_ns(wc_ns), .dq_out(dev_dq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		give_verdict();
	end

	// Write strobe only with select low, drive high and data driven
	always @(negedge clk) if (rst_b === 1'h1 && flash_we_b === 1'h0)
		check("we_qualifiers", 32'h3, {flash_ce_b, flash_oe_b, flash_data_oe});

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic give_verdict();
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic do_reset();
		rst_b <= 1'h0;
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
	endtask : do_reset

	// Request held until the edge that sees ready
	task automatic send(input sfpc_pkg::sfpc_op_t op, input logic [17:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_valid <= 1'h1;
		do begin
			@(negedge clk);
			n++;
		end while (cmd_ready !== 1'h1 && n < 20000);
		@(posedge clk);
		cmd_valid <= 1'h0;
		check("cmd_accept", 32'h1, n < 20000);
	endtask : send

	task automatic read_chk(input logic [17:0] a, input logic [7:0] exp);
		int n;
		send(sfpc_pkg::OP_READ, a, 8'h00);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rsp_valid !== 1'h1 && n < 40);
		check("rsp_latency", 32'h8, n);
		check("rsp_data", exp, rsp_data);
	endtask : read_chk

	// Cycles until busy rises, then cycles busy stays up
	task automatic finish_cycle(output int win, output int len);
		win = 0;
		len = 0;
		while (busy !== 1'h1 && win < 5000) begin
			@(negedge clk);
			win++;
		end
		while (busy === 1'h1 && len < 2000) begin
			@(negedge clk);
			len++;
		end
	endtask : finish_cycle

	task automatic wait_power();
		int n;
		n = 0;
		while (power_ready !== 1'h1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check("power_delay", 32'h1, n >= PWR_CYC && n <= PWR_CYC + 8);
	endtask : wait_power

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic s_power();
		@(negedge clk);
		check("idle_pins", 32'he, {flash_ce_b, flash_oe_b, flash_we_b, flash_data_oe});
		check("guard_flag", 32'h0, software_write_guard);
		wait_power();
		@(posedge clk);
		supply_ok <= 1'h0;
		repeat (6) @(negedge clk);
		check("power_low", 32'h0, power_ready);
		@(posedge clk);
		supply_ok <= 1'h1;
		wait_power();
	endtask : s_power

	task automatic s_full_sector();
		int win;
		int len;
		for (int i = 255; i >= 0; i--)
			send(sfpc_pkg::OP_LOAD, {10'h3, 8'(i)}, 8'(i) ^ 8'ha5);
		finish_cycle(win, len);
		check("window", 32'h1, win >= 3750 && win <= 3800);
		check("busy_span", 32'h1, !sfpc_flash_model_inst.prog && len < WC_CYC);
		check("cycle_error", 32'h0, cycle_error);
		check("incomplete", 32'h0, sector_incomplete);
		for (int k = 0; k < 256; k += 127)
			read_chk({10'h3, 8'(k)}, 8'(k) ^ 8'ha5);
	endtask : s_full_sector

	task automatic s_partial_slow();
		int win;
		int len;
		wc_ns = 12000;
		send(sfpc_pkg::OP_LOAD, {10'h5, 8'h21}, 8'h92);
		send(sfpc_pkg::OP_LOAD, {10'h5, 8'h20}, 8'h11);
		send(sfpc_pkg::OP_FINISH, 18'h00000, 8'h00);
		finish_cycle(win, len);
		check("incomplete", 32'h1, sector_incomplete);
		check("cycle_error", 32'h1, cycle_error);
		repeat (150) @(posedge clk);
		wc_ns = 4000;
		read_chk({10'h5, 8'h21}, 8'h92);
	endtask : s_partial_slow

	task automatic s_guard();
		int win;
		int len;
		send(sfpc_pkg::OP_GUARD, 18'h00000, 8'h00);
		finish_cycle(win, len);
		check("guard_flag", 32'h1, software_write_guard);
		@(posedge clk);
		guard_assume <= 1'h1;
		send(sfpc_pkg::OP_LOAD, {10'h7, 8'h10}, 8'h3e);
		send(sfpc_pkg::OP_FINISH, 18'h00000, 8'h00);
		finish_cycle(win, len);
		check("cycle_error", 32'h0, cycle_error);
		read_chk({10'h7, 8'h10}, 8'h3e);
		@(posedge clk);
		guard_assume <= 1'h0;
		do_reset();
		wait_power();
		check("guard_flag", 32'h0, software_write_guard);
		send(sfpc_pkg::OP_LOAD, {10'h7, 8'h10}, 8'h41);
		send(sfpc_pkg::OP_FINISH, 18'h00000, 8'h00);
		finish_cycle(win, len);
		check("busy_span", 32'h1, !sfpc_flash_model_inst.prog && len < WC_CYC);
		read_chk({10'h7, 8'h10}, 8'h3e);
	endtask : s_guard

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk_en <= 1'h1;
		cmd_valid <= 1'h0;
		cmd_op <= sfpc_pkg::OP_READ;
		cmd_addr <= 18'h00000;
		cmd_data <= 8'h00;
		guard_assume <= 1'h0;
		supply_ok <= 1'h1;
		wc_ns = 4000;
		do_reset();
		s_power();
		s_full_sector();
		s_partial_slow();
		s_guard();
		give_verdict();
	end
endmodule : tb_sfpc_host
